// File: logic/hbm_map.vh
// constants, register offsets and timing counts of the h-bridge motor control
`ifndef HBM_MAP_VH
`define HBM_MAP_VH
`define HBM_CLK_MHZ 100
`define HBM_DEAD_NS 140
`define HBM_DEAD_CYC ((`HBM_DEAD_NS * `HBM_CLK_MHZ + 999) / 1000)
`define HBM_OCFILT_NS 1000
`define HBM_OCFILT_CYC ((`HBM_OCFILT_NS * `HBM_CLK_MHZ) / 1000)
`define HBM_RETRY_NS 1000
`define HBM_RETRY_CYC ((`HBM_RETRY_NS * `HBM_CLK_MHZ) / 1000)
`define HBM_OCTMO_US 2000
`define HBM_OCTMO_CYC (`HBM_OCTMO_US * `HBM_CLK_MHZ)
`define HBM_DECAY_OFF_TIME_US 15
`define HBM_DECAY_OFF_TIME_CYC (`HBM_DECAY_OFF_TIME_US * `HBM_CLK_MHZ)
// register byte offsets
`define HBM_REG_CTRL 12'h000
`define HBM_REG_STAT 12'h004
// control fields
`define HBM_CTRL_ENN 0
`define HBM_CTRL_MODE 1
`define HBM_CTRL_PWM 2
`define HBM_CTRL_DIR 3
`define HBM_CTRL_FWD 4
`define HBM_CTRL_REV 5
`define HBM_CTRL_RST 32'h0000_0001
// drive codes of one output: hiz, low, high
`define HBM_OUT_HIZ 2'h0
`define HBM_OUT_LOW 2'h1
`define HBM_OUT_HIGH 2'h2
`endif

// File: logic/hbm_leg.v
// one bridge leg with dead-time insertion between its two switches
`timescale 1ns/1ps
`include "hbm_map.vh"
module hbm_leg #(
  parameter DEAD_CYC = `HBM_DEAD_CYC
) (
  input wire pclk,
  input wire presetn,
  input wire [1:0] want,
  output reg hs_on_ff,
  output reg ls_on_ff
);
  reg [7:0] dead_ff;
  reg [7:0] nxt_dead;
  reg nxt_hs;
  reg nxt_ls;
  wire want_hs;
  wire want_ls;
  assign want_hs = (want == `HBM_OUT_HIGH);
  assign want_ls = (want == `HBM_OUT_LOW);
  // a switch turns on only after the other has been off for the dead time
  always @* begin
    nxt_hs = hs_on_ff & want_hs;
    nxt_ls = ls_on_ff & want_ls;
    nxt_dead = dead_ff;
    if (hs_on_ff & ~want_hs) begin
      nxt_dead = DEAD_CYC[7:0]; // RL9
    end else if (ls_on_ff & ~want_ls) begin
      nxt_dead = DEAD_CYC[7:0]; // RL9
    end else if (dead_ff != 8'h00) begin
      nxt_dead = dead_ff - 8'h01;
    end else if (~hs_on_ff & ~ls_on_ff) begin
      nxt_hs = want_hs; // RL9
      nxt_ls = want_ls; // RL9
    end
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hs_on_ff <= 1'b0;
      ls_on_ff <= 1'b0;
      dead_ff <= 8'h00;
    end else begin
      hs_on_ff <= nxt_hs;
      ls_on_ff <= nxt_ls;
      dead_ff <= nxt_dead;
    end
  end
endmodule // hbm_leg

// File: logic/hbm_top.v
// h-bridge motor control logic with apb control and status registers
// Operation
// [RL1] overcurrent counts only after filter interval
// [RL2] overcurrent disables drivers, asserts fault low
// [RL3] persistent overcurrent past timeout enters autoretry
// [RL4] retry window re-enables outputs, releases fault
// [RL5] still overcurrent after retry: disable again
// [RL6] pwm high drives polarity chosen by dir
// [RL7] pwm low brakes with both low sides
// [RL8] fwd alone forward, rev alone swaps polarity
// [RL9] dead time between switches of one leg
// [RL10] over-temperature: outputs hiz, fault asserted
// [RL11] re-enable only at recovery temperature indication
// [RL12] over regulation threshold reverses drive for off-time
// [RL13] after off-time return to commanded drive
// [RL14] board grounds sense input to disable regulation
// [RL15] controller sets speed by pwm duty
// [RL16] controller may use bipolar or unipolar switching
// [RL17] enable high holds outputs hiz, shutdown
// [RL18] fault is active-low open drain
// [RL19] dir high: a high, b low; else opposite
// [RL20] fwd,rev both low brake; both high hiz
// [RL21] faults beat commands; off-time only while driving
//
// Decided for this implementation: the APB slave port and the register offsets.
`timescale 1ns/1ps
`include "hbm_map.vh"
module hbm_top #(
  parameter OCTMO_CYC = `HBM_OCTMO_CYC,
  parameter OCFILT_CYC = `HBM_OCFILT_CYC,
  parameter RETRY_CYC = `HBM_RETRY_CYC,
  parameter DECAY_OFF_TIME_CYC = `HBM_DECAY_OFF_TIME_CYC,
  parameter DEAD_CYC = `HBM_DEAD_CYC
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output wire pslverr,
  output reg [31:0] prdata,
  input wire overcurrent_in,
  input wire over_temp_in,
  input wire temp_recovered_in,
  input wire current_sense_in,
  output wire bridge_out_a_hi,
  output wire bridge_out_a_lo,
  output wire bridge_out_b_hi,
  output wire bridge_out_b_lo,
  output wire fault_n_out,
  output wire fault_n_oe
);
  localparam ST_RUN = 2'h0;
  localparam ST_OCOFF = 2'h1;
  localparam ST_RETRY = 2'h2;
  localparam ST_HOT = 2'h3;

  reg [31:0] ctrl_ff;
  reg [1:0] st_ff;
  reg [1:0] nxt_st;
  reg [23:0] tmr_ff;
  reg [23:0] nxt_tmr;
  reg [15:0] filt_ff;
  reg [15:0] decay_off_time_ff;
  reg [15:0] nxt_decay_off_time;
  reg [1:0] cmd_a;
  reg [1:0] cmd_b;
  reg [1:0] want_a;
  reg [1:0] want_b;
  wire ctl_enn;
  wire ctl_mode;
  wire ctl_pwm;
  wire ctl_dir;
  wire forward_drive_in;
  wire reverse_drive_in;
  wire oc_seen;
  wire driving;
  wire wr_en;
  wire rd_en;
  wire addr_ok;
  wire a_hs;
  wire a_ls;
  wire b_hs;
  wire b_ls;

  assign ctl_enn = ctrl_ff[`HBM_CTRL_ENN];
  assign ctl_mode = ctrl_ff[`HBM_CTRL_MODE];
  assign ctl_pwm = ctrl_ff[`HBM_CTRL_PWM];
  assign ctl_dir = ctrl_ff[`HBM_CTRL_DIR];
  assign forward_drive_in = ctrl_ff[`HBM_CTRL_FWD];
  assign reverse_drive_in = ctrl_ff[`HBM_CTRL_REV];

  // apb slave: zero wait states, error on unmapped address
  assign addr_ok = (paddr == `HBM_REG_CTRL) | (paddr == `HBM_REG_STAT);
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~addr_ok;
  assign wr_en = psel & penable & pwrite & (paddr == `HBM_REG_CTRL);
  assign rd_en = psel & ~penable & ~pwrite;

  // control register write
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= `HBM_CTRL_RST;
    end else if (wr_en) begin
      ctrl_ff <= {26'h0, pwdata[5:0]};
    end
  end

  // read data captured in the setup cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (rd_en) begin
      if (paddr == `HBM_REG_CTRL) begin
        prdata <= ctrl_ff;
      end else if (paddr == `HBM_REG_STAT) begin
        prdata <= {24'h0, a_hs, a_ls, b_hs, b_ls, ~fault_n_oe,
          decay_off_time_ff != 16'h0, st_ff};
      end else begin
        prdata <= 32'h0;
      end
    end
  end

  // overcurrent detection filter
  assign oc_seen = (filt_ff >= OCFILT_CYC[15:0]); // RL1
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      filt_ff <= 16'h0;
    end else if (!overcurrent_in) begin
      filt_ff <= 16'h0; // RL1
    end else if (!oc_seen) begin
      filt_ff <= filt_ff + 16'h1;
    end
  end

  // protection state machine
  always @* begin
    nxt_st = st_ff;
    nxt_tmr = tmr_ff;
    case (st_ff)
      ST_RUN: begin
        if (over_temp_in) begin
          nxt_st = ST_HOT; // RL10
        end else if (oc_seen) begin
          nxt_st = ST_OCOFF; // RL2
          nxt_tmr = 24'h0;
        end
      end
      ST_OCOFF: begin
        if (over_temp_in) begin
          nxt_st = ST_HOT;
        end else if (!overcurrent_in) begin
          nxt_st = ST_RUN;
        end else if (tmr_ff >= OCTMO_CYC[23:0] - 24'h1) begin
          nxt_st = ST_RETRY; // RL3
          nxt_tmr = 24'h0;
        end else begin
          nxt_tmr = tmr_ff + 24'h1;
        end
      end
      ST_RETRY: begin
        if (over_temp_in) begin
          nxt_st = ST_HOT;
        end else if (tmr_ff >= RETRY_CYC[23:0] - 24'h1) begin
          nxt_tmr = 24'h0;
          nxt_st = overcurrent_in ? ST_OCOFF : ST_RUN; // RL5
        end else begin
          nxt_tmr = tmr_ff + 24'h1; // RL4
        end
      end
      ST_HOT: begin
        if (temp_recovered_in && !over_temp_in) begin
          nxt_st = ST_RUN; // RL11
        end
      end
      default: begin
        nxt_st = ST_RUN;
      end
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= ST_RUN;
      tmr_ff <= 24'h0;
    end else begin
      st_ff <= nxt_st;
      tmr_ff <= nxt_tmr;
    end
  end

  // commanded output states from the control inputs
  always @* begin
    cmd_a = `HBM_OUT_LOW;
    cmd_b = `HBM_OUT_LOW;
    if (!ctl_mode) begin
      if (ctl_pwm && ctl_dir) begin
        cmd_a = `HBM_OUT_HIGH; // RL6 RL19
      end else if (ctl_pwm) begin
        cmd_b = `HBM_OUT_HIGH; // RL6 RL19
      end
      // pwm low keeps both low: brake RL7
    end else begin
      if (forward_drive_in && reverse_drive_in) begin
        cmd_a = `HBM_OUT_HIZ; // RL20
        cmd_b = `HBM_OUT_HIZ;
      end else if (forward_drive_in) begin
        cmd_a = `HBM_OUT_HIGH; // RL8
      end else if (reverse_drive_in) begin
        cmd_b = `HBM_OUT_HIGH; // RL8
      end
      // both low: brake RL20
    end
  end

  // off-time runs only while one output is driven high
  assign driving = (cmd_a == `HBM_OUT_HIGH) | (cmd_b == `HBM_OUT_HIGH);
  always @* begin
    nxt_decay_off_time = decay_off_time_ff;
    if (ctl_enn || st_ff != ST_RUN && st_ff != ST_RETRY || !driving) begin
      nxt_decay_off_time = 16'h0; // RL21
    end else if (decay_off_time_ff != 16'h0) begin
      nxt_decay_off_time = decay_off_time_ff - 16'h1; // RL13
    end else if (current_sense_in) begin
      nxt_decay_off_time = DECAY_OFF_TIME_CYC[15:0]; // RL12
    end
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      decay_off_time_ff <= 16'h0;
    end else begin
      decay_off_time_ff <= nxt_decay_off_time;
    end
  end

  // final priority: enable, faults, decay reversal, command
  always @* begin
    want_a = cmd_a;
    want_b = cmd_b;
    if (ctl_enn) begin
      want_a = `HBM_OUT_HIZ; // RL17
      want_b = `HBM_OUT_HIZ;
    end else if (st_ff == ST_OCOFF || st_ff == ST_HOT) begin
      want_a = `HBM_OUT_HIZ; // RL2 RL10 RL21
      want_b = `HBM_OUT_HIZ;
    end else if (decay_off_time_ff != 16'h0) begin
      want_a = cmd_b; // RL12
      want_b = cmd_a;
    end
  end

  hbm_leg #(.DEAD_CYC(DEAD_CYC)) u_leg_a (
    .pclk(pclk),
    .presetn(presetn),
    .want(want_a),
    .hs_on_ff(a_hs),
    .ls_on_ff(a_ls)
  );
  hbm_leg #(.DEAD_CYC(DEAD_CYC)) u_leg_b (
    .pclk(pclk),
    .presetn(presetn),
    .want(want_b),
    .hs_on_ff(b_hs),
    .ls_on_ff(b_ls)
  );
  assign bridge_out_a_hi = a_hs;
  assign bridge_out_a_lo = a_ls;
  assign bridge_out_b_hi = b_hs;
  assign bridge_out_b_lo = b_ls;

  // open-drain fault: drive low in overcurrent off or thermal shutdown
  assign fault_n_out = 1'b0; // RL18
  assign fault_n_oe = (st_ff == ST_OCOFF) | (st_ff == ST_HOT); // RL2 RL4
endmodule // hbm_top

// File: verif/hbm_props.sv
// port checker of the h-bridge motor control
`timescale 1ns/1ps
module hbm_props #(
  parameter OCTMO_CYC = 50
) (
  input wire pclk,
  input wire presetn,
  input wire overcurrent_in,
  input wire over_temp_in,
  input wire temp_recovered_in,
  input wire bridge_out_a_hi,
  input wire bridge_out_a_lo,
  input wire bridge_out_b_hi,
  input wire bridge_out_b_lo,
  input wire fault_n_out,
  input wire fault_n_oe
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire any_on = bridge_out_a_hi | bridge_out_a_lo | bridge_out_b_hi |
    bridge_out_b_lo;
  reg [7:0] hold_ff;
  // counts cycles of fault held while overcurrent persists
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      hold_ff <= 8'h00;
    else if (fault_n_oe && overcurrent_in && !over_temp_in)
      hold_ff <= hold_ff + 8'h01;
    else
      hold_ff <= 8'h00;
  end
  property p_dead_a;
    $fell(bridge_out_a_lo) |-> !bridge_out_a_hi [*8];
  endproperty
  a_dead_a: assert property (p_dead_a) else $error("no dead time");
  property p_dead_b;
    $fell(bridge_out_b_lo) |-> !bridge_out_b_hi [*8];
  endproperty
  a_dead_b: assert property (p_dead_b) else $error("no dead time b");
  property p_fault_low;
    fault_n_out == 1'b0;
  endproperty
  a_fault_low: assert property (p_fault_low) else $error("fault drive");
  property p_hot;
    over_temp_in [*3] |-> fault_n_oe && !any_on;
  endproperty
  a_hot: assert property (p_hot) else $error("hot not off");
  property p_hot_hold;
    over_temp_in ##1 !temp_recovered_in [*3] |-> fault_n_oe;
  endproperty
  a_hot_hold: assert property (p_hot_hold) else $error("early");
  property p_filter;
    $rose(overcurrent_in) && !fault_n_oe && !over_temp_in |-> !fault_n_oe [*5];
  endproperty
  a_filter: assert property (p_filter) else $error("no filter");
  property p_oc_off;
    $rose(overcurrent_in) ##1 overcurrent_in [*6] |-> ##[1:3]
      (fault_n_oe && !any_on);
  endproperty
  a_oc_off: assert property (p_oc_off) else $error("oc not off");
  property p_retry;
    $fell(fault_n_oe) && overcurrent_in |-> !fault_n_oe [*4] ##[1:3] fault_n_oe;
  endproperty
  a_retry: assert property (p_retry) else $error("retry window");
  property p_retry_time;
    $fell(fault_n_oe) && overcurrent_in |-> hold_ff > OCTMO_CYC - 10 &&
      hold_ff < OCTMO_CYC + 10;
  endproperty
  a_retry_time: assert property (p_retry_time) else $error("timeout");
endmodule // hbm_props
bind hbm_top hbm_props #(.OCTMO_CYC(OCTMO_CYC)) u_props (.pclk, .presetn,
  .overcurrent_in, .over_temp_in, .temp_recovered_in, .bridge_out_a_hi,
  .bridge_out_a_lo, .bridge_out_b_hi, .bridge_out_b_lo, .fault_n_out,
  .fault_n_oe);

// File: verif/hbm_env.sv
// sensor and fault line model around the motor control logic
`timescale 1ns/1ps
module hbm_env (
  input wire pclk,
  input wire [3:0] env,
  input wire fault_n_out,
  input wire fault_n_oe,
  output reg overcurrent_in = 1'b0,
  output reg over_temp_in = 1'b0,
  output reg temp_recovered_in = 1'b1,
  output reg current_sense_in = 1'b0,
  output wire fault_pin
);
  // sensor comparators land in the clock domain one edge late
  always @(posedge pclk) begin
    overcurrent_in <= env[0];
    over_temp_in <= env[1];
    temp_recovered_in <= env[2];
    current_sense_in <= env[3];
  end
  // open-drain fault line with board pull-up
  assign fault_pin = fault_n_oe ? fault_n_out : 1'b1;
endmodule // hbm_env

// File: verif/hbm_top_tb.sv
// self-checking bench of the h-bridge motor control
`timescale 1ns/1ps
module hbm_top_tb;
  reg pclk = 1'b0;
  reg presetn = 1'b0;
  reg psel = 1'b0;
  reg penable = 1'b0;
  reg pwrite = 1'b0;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h0;
  reg [3:0] env = 4'h4;
  reg [31:0] rd;
  reg err;
  integer error_cnt = 0;
  integer check_count = 0;
  integer cyc = 0;
  integer m;
  integer i;
  wire pready, pslverr, fault_n_out, fault_n_oe, fault_pin;
  wire overcurrent_in, over_temp_in, temp_recovered_in, current_sense_in;
  wire bridge_out_a_hi, bridge_out_a_lo, bridge_out_b_hi, bridge_out_b_lo;
  wire [31:0] prdata;
  wire [3:0] outs = {bridge_out_a_hi, bridge_out_a_lo, bridge_out_b_hi,
    bridge_out_b_lo};
  hbm_top #(.OCTMO_CYC(50), .OCFILT_CYC(5), .RETRY_CYC(5), .DECAY_OFF_TIME_CYC(20))
    dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .pslverr, .prdata, .overcurrent_in, .over_temp_in, .temp_recovered_in,
    .current_sense_in, .bridge_out_a_hi, .bridge_out_a_lo, .bridge_out_b_hi,
    .bridge_out_b_lo, .fault_n_out, .fault_n_oe);
  hbm_env u_env (.pclk, .env, .fault_n_out, .fault_n_oe, .overcurrent_in,
    .over_temp_in, .temp_recovered_in, .current_sense_in, .fault_pin);
  always #5 pclk = ~pclk;
  // cuts a hung run short
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt = error_cnt + 1;
      finish_test;
    end
  end
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      check_count = check_count + 1;
      if (seen !== exp) begin
        error_cnt = error_cnt + 1;
        $display("ERROR t=%0t seen %h exp %h", $time, seen, exp);
      end
    end
  endtask
  task apb(input w, input [11:0] a, input [31:0] d);
    begin
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task want(input [3:0] exp);
    integer n;
    begin
      n = 0;
      while (outs !== exp && n < 60) begin
        @(negedge pclk);
        n = n + 1;
      end
      chk(outs, exp);
    end
  endtask
  task pin(input v);
    integer n;
    begin
      n = 0;
      while (fault_pin !== v && n < 200) begin
        @(negedge pclk);
        n = n + 1;
      end
      chk(fault_pin, v);
    end
  endtask
  task setenv(input [3:0] e);
    @(posedge pclk) env <= e;
  endtask
  task t_regs;
    begin
      apb(1'b0, 12'h000, 32'h0);
      chk(rd, 32'h1);
      apb(1'b1, 12'h000, 32'h3d);
      repeat (30) @(negedge pclk);
      chk(outs, 4'h0);
      apb(1'b1, 12'h008, 32'hff);
      chk(err, 1'b1);
      apb(1'b0, 12'h008, 32'h0);
      chk(err, 1'b1);
      chk(rd, 32'h0);
      apb(1'b0, 12'h000, 32'h0);
      chk(rd, 32'h3d);
      $display("test regs done");
    end
  endtask
  task t_cmd;
    for (m = 0; m < 2; m = m + 1)
      for (i = 0; i < 4; i = m ? i + 1 : i + 1) begin
        apb(1'b1, 12'h000, m ? 32'h2 | (i << 4) : i << 2);
        if (m)
          want(i == 0 ? 4'h5 : i == 1 ? 4'h9 : i == 2 ? 4'h6 : 4'h0);
        else
          want(!i[0] ? 4'h5 : i[1] ? 4'h9 : 4'h6);
      end
  endtask
  task t_reg;
    begin
      apb(1'b1, 12'h000, 32'h0);
      want(4'h5);
      setenv(4'hc);
      setenv(4'h4);
      apb(1'b0, 12'h004, 32'h0);
      chk(rd, 32'h58);
      repeat (30) @(negedge pclk);
      chk(outs, 4'h5);
      apb(1'b1, 12'h000, 32'hc);
      want(4'h9);
      setenv(4'hc);
      setenv(4'h4);
      want(4'h6);
      want(4'h9);
      $display("test regulation done");
    end
  endtask
  task t_oc;
    begin
      setenv(4'h5);
      want(4'h0);
      pin(1'b0);
      pin(1'b1);
      want(4'h9);
      pin(1'b0);
      setenv(4'h4);
      want(4'h9);
      pin(1'b1);
      $display("test overcurrent done");
    end
  endtask
  task t_hot;
    begin
      setenv(4'h2);
      want(4'h0);
      pin(1'b0);
      setenv(4'h0);
      repeat (20) @(negedge pclk);
      chk({fault_pin, outs}, 5'h00);
      apb(1'b0, 12'h004, 32'h0);
      chk(rd, 32'h3);
      setenv(4'h4);
      want(4'h9);
      pin(1'b1);
      apb(1'b1, 12'h000, 32'hd);
      want(4'h0);
      $display("test thermal done");
    end
  endtask
  task finish_test;
    begin
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  // reset, then the scenarios in turn
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_cmd;
    $display("test commands done");
    t_reg;
    t_oc;
    t_hot;
    finish_test;
  end
endmodule // hbm_top_tb
